// [inc/eu_pkg.sv]
// package of constants and types for the enhanced uart with baud generator
// Contract
// RULE1: timer 2 overflow never offered as source
// RULE2: mode 0 data on rxd, clock on txd
// RULE3: mode 0 rate fixed at core clock/16
// RULE4: 8-bit framed: start, 8 data, stop
// RULE5: 8-bit framed rx keeps stop in rx_ninth_bit
// RULE6: 9-bit framed: start, 9 data, stop
// RULE7: 9-bit framed rx keeps ninth bit only
// RULE8: mode 2 rate core clock/32 or /16
// RULE9: mode 3 equals mode 2 except rate
// RULE10: any buffer write starts transmission
// RULE11: mode 0 rx starts when done 0, enable 1; code also waits for the transmitter to be idle
// RULE12: framed rx starts on start bit if enabled
// RULE13: timer 1 rate (256-reload) times 64 or 32
// RULE14: generator rate divisor plus 16, no doubling
// RULE15: generator counts core clock, picked by select
// RULE16: software loads divisor only while generator off; code accepts divisor writes while generator on too
// RULE17: generator control: bit0 on, bit1 pick
// RULE18: stop sampled 0 flags framing error
// RULE19: error view makes control bit 7 the error flag
// RULE20: software sets mode bits with error view 0
// RULE21: mode bits 00,01,10,11 select four modes
// RULE22: rx done set end bit 8 or mid stop
// RULE23: tx done set end bit 8 or at stop
// RULE24: txd idles high between frames
package eu_pkg;

    // ****************************************************************
    // register indices (byte address is four times the index)
    // ****************************************************************
    localparam logic [7:0] IDX_POWER_CONTROL = 8'h87;
    localparam logic [7:0] IDX_SERIAL_CONTROL = 8'h98;
    localparam logic [7:0] IDX_SERIAL_BUFFER = 8'h99;
    localparam logic [7:0] IDX_STATION_ADDRESS = 8'hA9;
    localparam logic [7:0] IDX_STATION_ADDRESS_MASK = 8'hB9;
    localparam logic [7:0] IDX_SERIAL_STATUS = 8'hBA;
    localparam logic [7:0] IDX_BAUD_GENERATOR_CONTROL = 8'hBD;
    localparam logic [7:0] IDX_BAUD_DIVISOR_LOW = 8'hBE;
    localparam logic [7:0] IDX_BAUD_DIVISOR_HIGH = 8'hBF;
    localparam int APB_ADDR_W = 12;

    // ****************************************************************
    // field positions
    // ****************************************************************
    localparam int PC_BAUD_DOUBLE = 7;
    localparam int PC_ERROR_VIEW = 6;
    localparam int SC_MODE_UPPER = 7;
    localparam int SC_MODE_LOWER = 6;
    localparam int SC_MULTIPROC = 5;
    localparam int SC_RX_ENABLE = 4;
    localparam int SC_TX_NINTH = 3;
    localparam int SC_RX_NINTH = 2;
    localparam int SC_TX_DONE = 1;
    localparam int SC_RX_DONE = 0;
    localparam int SS_FRAMING_ERROR = 3;
    localparam int BG_ON = 0;
    localparam int BG_PICK = 1;

    // ****************************************************************
    // modes and bit-rate figures
    // ****************************************************************
    localparam logic [1:0] MODE_SHIFT = 2'h0;
    localparam logic [1:0] MODE_8BIT = 2'h1;
    localparam logic [1:0] MODE_9BIT_FIXED = 2'h2;
    localparam logic [1:0] MODE_9BIT_VAR = 2'h3;
    localparam logic [17:0] DIV_SHIFT = 18'h00010;
    localparam logic [17:0] DIV_FIXED_SLOW = 18'h00020;
    localparam logic [17:0] DIV_FIXED_FAST = 18'h00010;
    localparam logic [17:0] DIV_GEN_ADD = 18'h00010;
    localparam logic [17:0] TIMER1_SPAN = 18'h00100;
    localparam int TIMER1_SHIFT_SLOW = 6;
    localparam int TIMER1_SHIFT_FAST = 5;
    localparam logic [3:0] BITS_SHIFT = 4'h8;
    localparam logic [3:0] BITS_FRAME8 = 4'hA;
    localparam logic [3:0] BITS_FRAME9 = 4'hB;

    typedef enum logic [0:0] {TX_IDLE, TX_SHIFT} eu_tx_e;
    typedef enum logic [2:0] {RX_IDLE, RX_START, RX_BITS, RX_STOP,
        RX_SYNC} eu_rx_e;

endpackage : eu_pkg

// [rtl/eu_uart.sv]
// enhanced uart with baud generator, apb register slave
`timescale 1ns/1ps
module eu_uart (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [eu_pkg::APB_ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [7:0] timer1_reload_byte,
    input wire logic rxd_in,
    output logic rxd_out,
    output logic rxd_oe,
    output logic txd_out
);
    import eu_pkg::*;

    // ****************************************************************
    // state
    // ****************************************************************
    typedef struct packed {
        logic baud_double_select;
        logic error_view_select;
        logic mode_bit_upper;
        logic mode_bit_lower;
        logic multiproc;
        logic rx_enable;
        logic tx_ninth_bit;
        logic rx_ninth_bit;
        logic tx_done_flag;
        logic rx_done_flag;
        logic framing_error_flag;
        logic [7:0] rx_buf;
        logic [7:0] station_address;
        logic [7:0] station_address_mask;
        logic baud_gen_on;
        logic baud_gen_pick;
        logic [7:0] baud_divisor_low;
        logic [7:0] baud_divisor_high;
        eu_tx_e tx_st;
        logic [10:0] tx_sh;
        logic [17:0] tx_cnt;
        logic [3:0] tx_bits;
        eu_rx_e rx_st;
        logic [8:0] rx_sh;
        logic [17:0] rx_cnt;
        logic [3:0] rx_bits;
        logic rxd_prev;
        logic txd;
        logic rxd_o;
        logic rxd_en;
        logic [31:0] rdata;
        logic ready;
        logic err;
    } eu_state_s;

    eu_state_s s_q;
    eu_state_s s_d;

    // ****************************************************************
    // helpers
    // ****************************************************************
    // cycles per bit for the current setting
    function automatic logic [17:0] eu_period(input logic [1:0] mode,
        input logic dbl, input logic pick, input logic [15:0] div,
        input logic [7:0] reload);
        logic [17:0] span;
        span = TIMER1_SPAN - {10'h000, reload};
        unique case (mode)
            MODE_SHIFT: eu_period = DIV_SHIFT; // RULE3
            MODE_9BIT_FIXED: eu_period = dbl ? DIV_FIXED_FAST
                : DIV_FIXED_SLOW; // RULE8
            default: begin
                // only generator or timer 1; no timer 2 path exists
                if (pick) begin // RULE1
                    eu_period = {2'h0, div} + DIV_GEN_ADD; // RULE14
                end else begin
                    eu_period = dbl ? (span << TIMER1_SHIFT_FAST)
                        : (span << TIMER1_SHIFT_SLOW); // RULE13
                end
            end
        endcase
    endfunction : eu_period

    // register index decode, shared by read and write
    function automatic logic eu_mapped(input logic [7:0] idx);
        eu_mapped = (idx == IDX_POWER_CONTROL) ||
            (idx == IDX_SERIAL_CONTROL) || (idx == IDX_SERIAL_BUFFER) ||
            (idx == IDX_STATION_ADDRESS) ||
            (idx == IDX_STATION_ADDRESS_MASK) ||
            (idx == IDX_SERIAL_STATUS) ||
            (idx == IDX_BAUD_GENERATOR_CONTROL) ||
            (idx == IDX_BAUD_DIVISOR_LOW) || (idx == IDX_BAUD_DIVISOR_HIGH);
    endfunction : eu_mapped

    logic [7:0] idx;
    logic addr_ok;
    logic [1:0] mode;
    logic framed;
    logic [17:0] period;
    logic run;
    logic wr_now;
    logic [7:0] wb;
    logic [7:0] rd_val;

    // ****************************************************************
    // decode and baud setup
    // ****************************************************************
    // address index, mode and bit period
    assign idx = paddr[9:2];
    assign addr_ok = (paddr[1:0] == 2'h0) && (paddr[11:10] == 2'h0)
        && eu_mapped(idx);
    assign mode = {s_q.mode_bit_upper, s_q.mode_bit_lower}; // RULE21
    assign framed = (mode != MODE_SHIFT);
    assign period = eu_period(mode, s_q.baud_double_select,
        s_q.baud_gen_pick,
        {s_q.baud_divisor_high, s_q.baud_divisor_low},
        timer1_reload_byte); // RULE9
    // generator picked but stopped: bit timing holds
    assign run = !(mode[0] && s_q.baud_gen_pick && !s_q.baud_gen_on); // RULE15
    assign wr_now = psel && penable && s_q.ready && pwrite && addr_ok;
    assign wb = pwdata[7:0];

    // read mux
    always_comb begin
        rd_val = 8'h00;
        unique case (idx)
            IDX_POWER_CONTROL: begin
                rd_val[PC_BAUD_DOUBLE] = s_q.baud_double_select;
                rd_val[PC_ERROR_VIEW] = s_q.error_view_select;
            end
            IDX_SERIAL_CONTROL: begin
                rd_val = {s_q.error_view_select ? s_q.framing_error_flag
                    : s_q.mode_bit_upper, s_q.mode_bit_lower,
                    s_q.multiproc, s_q.rx_enable, s_q.tx_ninth_bit,
                    s_q.rx_ninth_bit, s_q.tx_done_flag,
                    s_q.rx_done_flag}; // RULE19
            end
            IDX_SERIAL_BUFFER: rd_val = s_q.rx_buf;
            IDX_STATION_ADDRESS: rd_val = s_q.station_address;
            IDX_STATION_ADDRESS_MASK: rd_val = s_q.station_address_mask;
            IDX_SERIAL_STATUS: begin
                rd_val[SS_FRAMING_ERROR] = s_q.framing_error_flag; // RULE18
            end
            IDX_BAUD_GENERATOR_CONTROL: begin
                rd_val[BG_ON] = s_q.baud_gen_on; // RULE17
                rd_val[BG_PICK] = s_q.baud_gen_pick;
            end
            IDX_BAUD_DIVISOR_LOW: rd_val = s_q.baud_divisor_low;
            IDX_BAUD_DIVISOR_HIGH: rd_val = s_q.baud_divisor_high;
            default: rd_val = 8'h00;
        endcase
    end

    // ****************************************************************
    // next state
    // ****************************************************************
    always_comb begin
        s_d = s_q;

        // apb: one wait state, answer on second access cycle
        s_d.ready = psel && penable && !s_q.ready;
        s_d.err = psel && penable && !s_q.ready && !addr_ok;
        // read data stands only in the answer cycle, zero otherwise
        s_d.rdata = (psel && penable && !s_q.ready && addr_ok && !pwrite)
            ? {24'h000000, rd_val} : 32'h00000000;

        // register writes; hardware sets below win over these
        if (wr_now) begin
            unique case (idx)
                IDX_POWER_CONTROL: begin
                    s_d.baud_double_select = wb[PC_BAUD_DOUBLE];
                    s_d.error_view_select = wb[PC_ERROR_VIEW];
                end
                IDX_SERIAL_CONTROL: begin
                    if (s_q.error_view_select) begin
                        s_d.framing_error_flag = wb[SC_MODE_UPPER]; // RULE19
                    end else begin
                        s_d.mode_bit_upper = wb[SC_MODE_UPPER];
                    end
                    s_d.mode_bit_lower = wb[SC_MODE_LOWER];
                    s_d.multiproc = wb[SC_MULTIPROC];
                    s_d.rx_enable = wb[SC_RX_ENABLE];
                    s_d.tx_ninth_bit = wb[SC_TX_NINTH];
                    s_d.rx_ninth_bit = wb[SC_RX_NINTH];
                    s_d.tx_done_flag = wb[SC_TX_DONE];
                    s_d.rx_done_flag = wb[SC_RX_DONE];
                end
                IDX_SERIAL_BUFFER: begin
                    // any buffer write loads and starts the transmitter
                    s_d.tx_st = TX_SHIFT; // RULE10
                    s_d.tx_cnt = period - 18'h00001;
                    s_d.tx_bits = 4'h0;
                    if (framed) begin
                        s_d.tx_sh = {1'b1, mode[1] ? s_q.tx_ninth_bit
                            : 1'b1, wb, 1'b0}; // RULE4 RULE6
                    end else begin
                        s_d.tx_sh = {3'h7, wb};
                    end
                end
                IDX_STATION_ADDRESS: s_d.station_address = wb;
                IDX_STATION_ADDRESS_MASK: s_d.station_address_mask = wb;
                IDX_BAUD_GENERATOR_CONTROL: begin
                    s_d.baud_gen_on = wb[BG_ON]; // RULE17
                    s_d.baud_gen_pick = wb[BG_PICK];
                end
                IDX_BAUD_DIVISOR_LOW: s_d.baud_divisor_low = wb; // RULE16
                IDX_BAUD_DIVISOR_HIGH: s_d.baud_divisor_high = wb;
                default: s_d.rdata = s_d.rdata;
            endcase
        end

        // transmitter
        unique case (s_q.tx_st)
            TX_IDLE: begin
                s_d.rxd_en = (s_q.rx_st == RX_SYNC);
            end
            TX_SHIFT: begin
                if (run) begin
                    if (s_q.tx_cnt == 18'h00000) begin
                        s_d.tx_cnt = period - 18'h00001;
                        s_d.tx_sh = {1'b1, s_q.tx_sh[10:1]};
                        s_d.tx_bits = s_q.tx_bits + 4'h1;
                        if (!framed && s_q.tx_bits == BITS_SHIFT - 4'h1) begin
                            s_d.tx_done_flag = 1'b1; // RULE23
                            s_d.tx_st = TX_IDLE;
                        end
                        if (framed && s_q.tx_bits == (mode[1] ? BITS_FRAME9
                            : BITS_FRAME8) - 4'h2) begin
                            s_d.tx_done_flag = 1'b1; // RULE23
                        end
                        if (framed && s_q.tx_bits == (mode[1] ? BITS_FRAME9
                            : BITS_FRAME8) - 4'h1) begin
                            s_d.tx_st = TX_IDLE;
                        end
                    end else begin
                        s_d.tx_cnt = s_q.tx_cnt - 18'h00001;
                    end
                end
                s_d.rxd_en = !framed; // RULE2
            end
        endcase

        // receiver
        s_d.rxd_prev = rxd_in;
        unique case (s_q.rx_st)
            RX_IDLE: begin
                if (!framed && s_q.tx_st == TX_IDLE && s_q.rx_enable &&
                    !s_q.rx_done_flag) begin
                    s_d.rx_st = RX_SYNC; // RULE11
                    s_d.rx_cnt = period - 18'h00001;
                    s_d.rx_bits = 4'h0;
                    s_d.rxd_en = 1'b0;
                end else if (framed && s_q.rx_enable && s_q.rxd_prev &&
                    !rxd_in) begin
                    s_d.rx_st = RX_START; // RULE12
                    s_d.rx_cnt = {1'b0, period[17:1]};
                    s_d.rx_bits = 4'h0;
                end
            end
            RX_START: begin
                if (run) begin
                    if (s_q.rx_cnt == 18'h00000) begin
                        s_d.rx_cnt = period - 18'h00001;
                        // glitch shorter than half a bit is dropped
                        s_d.rx_st = rxd_in ? RX_IDLE : RX_BITS;
                    end else begin
                        s_d.rx_cnt = s_q.rx_cnt - 18'h00001;
                    end
                end
            end
            RX_BITS: begin
                if (run) begin
                    if (s_q.rx_cnt == 18'h00000) begin
                        s_d.rx_cnt = period - 18'h00001;
                        s_d.rx_sh = {rxd_in, s_q.rx_sh[8:1]};
                        s_d.rx_bits = s_q.rx_bits + 4'h1;
                        if (s_q.rx_bits == (mode[1] ? BITS_SHIFT
                            : BITS_SHIFT - 4'h1)) begin
                            s_d.rx_st = RX_STOP;
                        end
                    end else begin
                        s_d.rx_cnt = s_q.rx_cnt - 18'h00001;
                    end
                end
            end
            RX_STOP: begin
                if (run) begin
                    if (s_q.rx_cnt == 18'h00000) begin
                        // stop bit sampled mid bit
                        s_d.rx_st = RX_IDLE;
                        s_d.rx_done_flag = 1'b1; // RULE22
                        if (mode[1]) begin
                            s_d.rx_buf = s_q.rx_sh[7:0];
                            s_d.rx_ninth_bit = s_q.rx_sh[8]; // RULE7
                        end else begin
                            s_d.rx_buf = s_q.rx_sh[8:1];
                            if (framed) begin
                                s_d.rx_ninth_bit = rxd_in; // RULE5
                            end
                        end
                        // mode 0 has no stop bit to judge
                        if (framed && !rxd_in) begin
                            s_d.framing_error_flag = 1'b1; // RULE18
                        end
                    end else begin
                        s_d.rx_cnt = s_q.rx_cnt - 18'h00001;
                    end
                end
            end
            RX_SYNC: begin
                s_d.rxd_en = 1'b0;
                if (s_q.rx_cnt == 18'h00000) begin
                    s_d.rx_cnt = period - 18'h00001;
                    s_d.rx_sh = {rxd_in, s_q.rx_sh[8:1]}; // RULE2
                    s_d.rx_bits = s_q.rx_bits + 4'h1;
                    if (s_q.rx_bits == BITS_SHIFT - 4'h1) begin
                        s_d.rx_st = RX_STOP;
                        s_d.rx_cnt = 18'h00000;
                    end
                end else begin
                    s_d.rx_cnt = s_q.rx_cnt - 18'h00001;
                end
            end
        endcase
        // mode 0 completes at end of eighth bit, no stop sample
        if (!framed && s_q.rx_st == RX_STOP) begin
            s_d.rx_st = RX_IDLE;
            s_d.rx_done_flag = 1'b1; // RULE22
            s_d.rx_buf = s_q.rx_sh[8:1];
        end

        // pins: mode 0 drives clock on txd and data on rxd
        s_d.rxd_o = s_d.tx_sh[0]; // RULE2
        if (!framed && (s_d.tx_st == TX_SHIFT || s_d.rx_st == RX_SYNC)) begin
            s_d.txd = (s_d.tx_st == TX_SHIFT) ?
                (s_d.tx_cnt < {1'b0, period[17:1]})
                : (s_d.rx_cnt < {1'b0, period[17:1]});
        end else if (framed && s_d.tx_st == TX_SHIFT) begin
            s_d.txd = s_d.tx_sh[0]; // RULE4 RULE6
        end else begin
            s_d.txd = 1'b1; // RULE24
        end
    end

    // ****************************************************************
    // state register
    // ****************************************************************
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            s_q <= '0;
            s_q.tx_st <= TX_IDLE;
            s_q.rx_st <= RX_IDLE;
            s_q.tx_sh <= 11'h7FF;
            s_q.rxd_prev <= 1'b1;
            s_q.txd <= 1'b1;
            s_q.rxd_o <= 1'b1;
        end else begin
            s_q <= s_d;
        end
    end

    // outputs straight from flip-flops
    assign prdata = s_q.rdata;
    assign pready = s_q.ready;
    assign pslverr = s_q.err;
    assign rxd_out = s_q.rxd_o;
    assign rxd_oe = s_q.rxd_en;
    assign txd_out = s_q.txd;

endmodule : eu_uart

// [bench/eu_uart_sva.sv]
// checker of register bus answers and serial pin timing of the uart
`timescale 1ns/1ps
module eu_uart_sva (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [eu_pkg::APB_ADDR_W-1:0] paddr,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic rxd_oe,
    input wire logic txd_out
);
    import eu_pkg::*;
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);

    // ****************************************************************
    // register bus answers
    // ****************************************************************
    a_ready_wait: assert property (psel && $rose(penable) |-> !pready ##1 pready)
        else $error("pready not after one wait state");
    a_ready_pulse: assert property (pready |=> !pready)
        else $error("pready longer than one cycle");
    a_ready_cause: assert property (pready |-> psel && $past(penable))
        else $error("pready outside an access");
    a_rdata_idle: assert property (!pready |-> prdata == 32'h0)
        else $error("read data outside answer");
    a_rdata_lane: assert property (pready |-> prdata[31:8] == 24'h0)
        else $error("read data upper lanes not zero");
    a_err_aligned: assert property (pready && paddr[1:0] != 2'h0 |-> pslverr)
        else $error("misaligned access not refused");
    a_err_quiet: assert property (pslverr |-> pready && prdata == 32'h0)
        else $error("refused access carries data");

    // ****************************************************************
    // serial pin timing
    // ****************************************************************
    a_low_min: assert property ($fell(txd_out) |-> !txd_out [*8])
        else $error("txd low shorter than half a shortest bit");
    a_shift_clock: assert property (rxd_oe && $fell(txd_out) |-> ##8 txd_out)
        else $error("shift clock low phase not eight cycles");

    // main scenarios reached
    c_refused: cover property (pslverr);
    c_read: cover property (pready && !pwrite);
    c_shift_tx: cover property ($rose(rxd_oe));
    c_frame_start: cover property (!rxd_oe && $fell(txd_out));
endmodule : eu_uart_sva

bind eu_uart eu_uart_sva i_sva (.clk_sys(clk_sys), .rst(rst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .rxd_oe(rxd_oe), .txd_out(txd_out));

// [bench/eu_station.sv]
// remote serial station that sends frames onto the receive pin
`timescale 1ns/1ps
module eu_station (
    input wire logic clk_sys,
    output logic rxd_line
);
    // line idles high, as with a pull-up
    initial rxd_line = 1'h1;

    // one frame: start low, data lsb first, stop, then release high
    task automatic send(input logic [8:0] d, input int nb, input logic stp,
        input int p);
        int k;
        rxd_line <= 1'h0;
        repeat (p) @(posedge clk_sys);
        for (k = 0; k < nb; k++) begin
            rxd_line <= d[k];
            repeat (p) @(posedge clk_sys);
        end
        rxd_line <= stp;
        repeat (p) @(posedge clk_sys);
        rxd_line <= 1'h1;
    endtask : send
endmodule : eu_station

// [bench/enhanced_uart_with_baud_generator_test.sv]
// self-checking bench of the uart through its register bus and pins
`timescale 1ns/1ps
module enhanced_uart_with_baud_generator_test;
    import eu_pkg::*;
    logic clk_sys = 1'h0;
    logic rst = 1'h1;
    logic psel = 1'h0;
    logic penable = 1'h0;
    logic pwrite = 1'h0;
    logic [11:0] paddr = 12'h0;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata, rd;
    logic pready, pslverr, rxd_out, rxd_oe, txd_out, stn_line, er;
    logic [7:0] t1r = 8'hFE;
    logic [7:0] dd;
    logic [10:0] ff;
    logic [7:0] sc[4], pc[4], bg[4];
    int pp[4];
    int n_fail = 0;
    int compares = 0;
    int i;
    // receive pin level from whoever drives it
    wire logic rxd_in = rxd_oe ? rxd_out : stn_line;

    eu_uart i_dut (.clk_sys(clk_sys), .rst(rst), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .timer1_reload_byte(t1r), .rxd_in(rxd_in), .rxd_out(rxd_out),
        .rxd_oe(rxd_oe), .txd_out(txd_out));
    eu_station i_stn (.clk_sys(clk_sys), .rxd_line(stn_line));

    // 200 MHz clock
    initial forever #2.5 clk_sys = ~clk_sys;

    task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        compares++;
        if (g !== e) begin
            n_fail++;
            $display("unexpected %s expected %h seen %h", nm, e, g);
        end
    endtask : chk

    // one bus transfer: setup, access until pready, then release
    task xfer(input logic w, input logic [11:0] a, input logic [7:0] d);
        int k;
        @(posedge clk_sys);
        psel <= 1'h1;
        pwrite <= w;
        paddr <= a;
        pwdata <= {24'h0, d};
        @(posedge clk_sys);
        penable <= 1'h1;
        for (k = 0; k < 50; k++) begin
            @(posedge clk_sys);
            if (pready === 1'h1) break;
        end
        rd = prdata;
        er = pslverr;
        if (k == 50) chk("pready", 1, 0);
        psel <= 1'h0;
        penable <= 1'h0;
    endtask : xfer

    task wr(input logic [7:0] x, input logic [7:0] d);
        xfer(1'h1, {2'h0, x, 2'h0}, d);
    endtask : wr

    task rc(input logic [7:0] x, input logic [7:0] m, input logic [7:0] e);
        xfer(1'h0, {2'h0, x, 2'h0}, 8'h0);
        chk($sformatf("register %h", x), {24'h0, e}, rd & {24'h0, m});
    endtask : rc

    // write the buffer, then sample each bit of the frame mid period
    task tx_frame(input logic [7:0] d, input logic [10:0] f, input int nb,
        input int p, input logic m0);
        int k;
        wr(IDX_SERIAL_BUFFER, d);
        repeat (p / 2 + 1) @(posedge clk_sys);
        for (k = 0; k < nb; k++) begin
            #1;
            chk("serial line", f[k], m0 ? rxd_out : txd_out);
            chk("drive enable", m0, rxd_oe);
            repeat (p) @(posedge clk_sys);
        end
        rc(IDX_SERIAL_CONTROL, 8'h02, 8'h02);
    endtask : tx_frame

    task report_and_stop;
        $display("compares %0d n_fail %0d", compares, n_fail);
        if (n_fail == 0 && compares > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : report_and_stop

    // watchdog against a hang
    initial begin
        repeat (20000) @(posedge clk_sys);
        chk("watchdog", 0, 1);
        report_and_stop;
    end

    // main sequence
    initial begin
        sc = '{8'h40, 8'h88, 8'h88, 8'hC0};
        pc = '{8'h00, 8'h00, 8'h80, 8'h80};
        bg = '{8'h03, 8'h03, 8'h03, 8'h01};
        pp = '{32, 32, 16, 64};
        repeat (4) @(posedge clk_sys);
        rst <= 1'h0;
        rc(IDX_SERIAL_CONTROL, 8'hFF, 8'h00);
        rc(IDX_BAUD_GENERATOR_CONTROL, 8'h03, 8'h00);
        xfer(1'h0, 12'h262, 8'h0);
        chk("slverr", 1, er);
        xfer(1'h0, 12'h000, 8'h0);
        chk("slverr", 1, er);
        tx_frame(8'h96, 11'h096, 8, 16, 1'h1);
        wr(IDX_SERIAL_CONTROL, 8'h10);
        repeat (8 * 16 + 4) @(posedge clk_sys);
        rc(IDX_SERIAL_CONTROL, 8'h01, 8'h01);
        rc(IDX_SERIAL_BUFFER, 8'hFF, 8'hFF);
        wr(IDX_BAUD_DIVISOR_LOW, 8'h10);
        wr(IDX_BAUD_DIVISOR_HIGH, 8'h00);
        rc(IDX_BAUD_DIVISOR_LOW, 8'hFF, 8'h10);
        for (i = 0; i < 4; i++) begin
            wr(IDX_POWER_CONTROL, pc[i]);
            wr(IDX_BAUD_GENERATOR_CONTROL, bg[i]);
            wr(IDX_SERIAL_CONTROL, sc[i]);
            dd = 8'hA5 ^ 8'(i);
            ff = (i == 0) ? {2'h3, dd, 1'h0} : {1'h1, sc[i][3], dd, 1'h0};
            tx_frame(dd, ff, (i == 0) ? 10 : 11, pp[i], 1'h0);
        end
        // framed reception, generator rate with doubling still set
        wr(IDX_BAUD_GENERATOR_CONTROL, 8'h03);
        wr(IDX_SERIAL_CONTROL, 8'h50);
        i_stn.send(9'h03C, 8, 1'h1, 32);
        rc(IDX_SERIAL_CONTROL, 8'h05, 8'h05);
        rc(IDX_SERIAL_BUFFER, 8'hFF, 8'h3C);
        wr(IDX_SERIAL_CONTROL, 8'h50);
        i_stn.send(9'h0C3, 8, 1'h0, 32);
        rc(IDX_SERIAL_STATUS, 8'h08, 8'h08);
        wr(IDX_POWER_CONTROL, 8'h40);
        rc(IDX_SERIAL_CONTROL, 8'h80, 8'h80);
        wr(IDX_POWER_CONTROL, 8'h00);
        rc(IDX_SERIAL_CONTROL, 8'h80, 8'h00);
        wr(IDX_SERIAL_CONTROL, 8'hD0);
        i_stn.send(9'h0AA, 9, 1'h1, 32);
        rc(IDX_SERIAL_CONTROL, 8'h05, 8'h01);
        rc(IDX_SERIAL_BUFFER, 8'hFF, 8'hAA);
        report_and_stop;
    end
endmodule : enhanced_uart_with_baud_generator_test
